// ### design/independent_watchdog_consts.svh
// Constants of the independent watchdog: offsets, keys, reset values, timing.
// Assumes inclusion by bare name from the package and the design module.
`ifndef INDEPENDENT_WATCHDOG_CONSTS_SVH
`define INDEPENDENT_WATCHDOG_CONSTS_SVH

// Register offsets
`define WDG_OFS_KEY 4'h0
`define WDG_OFS_DIV 4'h4
`define WDG_OFS_RLD 4'h8
`define WDG_OFS_STS 4'hc

// Key values
`define WDG_KEY_START 16'hcccc
`define WDG_KEY_REFRESH 16'haaaa
`define WDG_KEY_UNLOCK 16'h5555

// Reset values and widths
`define WDG_RLD_RESET 12'hfff
`define WDG_DIV_RESET 3'h0
`define WDG_CNT_ZERO 12'h000
`define WDG_PRE_ZERO 8'h00
`define WDG_PRE_MAX_CODE 3'h6
`define WDG_SYNC_ZERO 2'h0

// Field positions
`define WDG_FLAG_DIV_BIT 0
`define WDG_FLAG_RLD_BIT 1

// Reset pulse on timeout lasts this many low-speed cycles plus one
`define WDG_RESET_PULSE_TICKS 4'h4
`define WDG_TICK_ZERO 4'h0

`endif

// ### design/independent_watchdog_pkg.sv
// Types of the independent watchdog.
// Assumes the constants header is on the include path.
`include "independent_watchdog_consts.svh"

package independent_watchdog_pkg;

    // Register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    // Counter state
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN = 3'h2,
        ST_FIRE = 3'h4
    } wdg_state_t;

endpackage

// ### design/independent_watchdog.sv
// Independent watchdog: bus-side register file and low-speed counter domain.
// Assumes a synchronous register port on clk_in and a free-running lsi clock.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "independent_watchdog_consts.svh"

module independent_watchdog (
    // Bus clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Low-speed internal clock
    input wire logic low_speed_internal_clock_in,
    // Register port
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // Configuration
    input wire logic hw_watchdog_in,
    input wire logic debug_halt_in,
    input wire logic debug_config_stop_in,
    input wire logic standby_in,
    // System reset request and running status
    output logic sys_reset_out,
    output logic running_out
);

    // ------------------------------------------------------------
    // Bus side decode
    // ------------------------------------------------------------
    independent_watchdog_pkg::bus_req_t req;
    assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    wire key_wr = req.wr && (req.addr == `WDG_OFS_KEY);
    wire div_wr = req.wr && (req.addr == `WDG_OFS_DIV);
    wire rld_wr = req.wr && (req.addr == `WDG_OFS_RLD);
    wire [15:0] key_val = req.wdata[15:0];
    wire key_start = key_wr && (key_val == `WDG_KEY_START);
    wire key_refresh = key_wr && (key_val == `WDG_KEY_REFRESH);
    wire key_unlock = key_wr && (key_val == `WDG_KEY_UNLOCK);

    logic unlocked;
    logic [2:0] div_code;
    logic [11:0] reload;
    logic div_pending;
    logic rld_pending;

    wire div_accept = div_wr && unlocked && !div_pending;
    wire rld_accept = rld_wr && unlocked && !rld_pending;

    wire next_unlocked = key_wr ? key_unlock : unlocked;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            unlocked <= 1'b0;
        end else if (standby_in) begin
            unlocked <= 1'b0;
        end else begin
            unlocked <= next_unlocked;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_code <= `WDG_DIV_RESET;
        end else if (div_accept) begin
            div_code <= req.wdata[2:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reload <= `WDG_RLD_RESET;
        end else if (standby_in) begin
            reload <= `WDG_RLD_RESET;
        end else if (rld_accept) begin
            reload <= req.wdata[11:0];
        end
    end

    // ------------------------------------------------------------
    // Crossing: toggle events bus to low-speed, acks back
    // ------------------------------------------------------------
    logic div_tog;
    logic rld_tog;
    logic start_tog;
    logic refr_tog;
    logic [1:0] div_ack_sync;
    logic [1:0] rld_ack_sync;
    logic div_ack_tog;
    logic rld_ack_tog;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_tog <= 1'b0;
            rld_tog <= 1'b0;
            start_tog <= 1'b0;
            refr_tog <= 1'b0;
        end else begin
            div_tog <= div_tog ^ div_accept;
            rld_tog <= rld_tog ^ rld_accept;
            start_tog <= start_tog ^ key_start;
            refr_tog <= refr_tog ^ key_refresh;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_ack_sync <= `WDG_SYNC_ZERO;
            rld_ack_sync <= `WDG_SYNC_ZERO;
        end else begin
            div_ack_sync <= {div_ack_sync[0], div_ack_tog};
            rld_ack_sync <= {rld_ack_sync[0], rld_ack_tog};
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_pending <= 1'b0;
            rld_pending <= 1'b0;
        end else begin
            div_pending <= (div_tog ^ div_accept) != div_ack_sync[1];
            rld_pending <= (rld_tog ^ rld_accept) != rld_ack_sync[1];
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // key reads zero; reads valid when flag clear
    wire [31:0] rd_mux =
        (req.addr == `WDG_OFS_DIV) ? {29'h0, div_code} :
        (req.addr == `WDG_OFS_RLD) ? {20'h0, reload} :
        (req.addr == `WDG_OFS_STS) ? {30'h0, rld_pending, div_pending} :
        32'h0;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 32'h0;
        end else begin
            rdata_out <= req.rd ? rd_mux : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Low-speed domain
    // ------------------------------------------------------------
    // Reset is released into this domain synchronously
    logic [1:0] lsr_sync;
    always_ff @(posedge low_speed_internal_clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lsr_sync <= `WDG_SYNC_ZERO;
        end else begin
            lsr_sync <= {lsr_sync[0], 1'b1};
        end
    end
    wire ls_rst_n = lsr_sync[1];

    logic [2:0] div_s;
    logic [2:0] rld_s;
    logic [2:0] start_s;
    logic [2:0] refr_s;
    logic [2:0] ls_code;
    logic [11:0] ls_reload;
    logic [7:0] pre;
    logic [11:0] cnt;
    logic [3:0] fire_ticks;
    logic hw_seen;
    logic [1:0] halt_s;
    logic [1:0] stop_s;
    independent_watchdog_pkg::wdg_state_t state;

    // Divider terminal count: code n divides by 4 << n, code 7 as code 6
    function automatic logic [7:0] pre_top(input logic [2:0] code);
        logic [2:0] c;
        c = (code > `WDG_PRE_MAX_CODE) ? `WDG_PRE_MAX_CODE : code;
        pre_top = 8'((9'h4 << c) - 9'h1);
    endfunction

    // Data words are stable while pending, except reload on standby, so sampling after the toggle is safe
    always_ff @(posedge low_speed_internal_clock_in or negedge ls_rst_n) begin
        if (!ls_rst_n) begin
            div_s <= 3'h0;
            rld_s <= 3'h0;
            start_s <= 3'h0;
            refr_s <= 3'h0;
            halt_s <= `WDG_SYNC_ZERO;
            stop_s <= `WDG_SYNC_ZERO;
        end else begin
            div_s <= {div_s[1:0], div_tog};
            rld_s <= {rld_s[1:0], rld_tog};
            start_s <= {start_s[1:0], start_tog};
            refr_s <= {refr_s[1:0], refr_tog};
            halt_s <= {halt_s[0], debug_halt_in};
            stop_s <= {stop_s[0], debug_config_stop_in};
        end
    end

    wire div_evt = div_s[2] ^ div_s[1];
    wire rld_evt = rld_s[2] ^ rld_s[1];
    wire start_evt = start_s[2] ^ start_s[1];
    wire refr_evt = refr_s[2] ^ refr_s[1];

    always_ff @(posedge low_speed_internal_clock_in or negedge ls_rst_n) begin
        if (!ls_rst_n) begin
            ls_code <= `WDG_DIV_RESET;
            ls_reload <= `WDG_RLD_RESET;
            div_ack_tog <= 1'b0;
            rld_ack_tog <= 1'b0;
        end else begin
            if (div_evt) begin
                ls_code <= div_code;
                div_ack_tog <= div_s[1];
            end
            if (rld_evt) begin
                ls_reload <= reload;
                rld_ack_tog <= rld_s[1];
            end
        end
    end

    wire frozen = halt_s[1] && stop_s[1];
    // prescaler tick
    // At or past the top, so a smaller divider cannot strand the prescaler above it
    wire tick = (pre >= pre_top(ls_code));

    wire next_start = start_evt || (hw_watchdog_in && !hw_seen);
    always_ff @(posedge low_speed_internal_clock_in or negedge ls_rst_n) begin
        if (!ls_rst_n) begin
            state <= independent_watchdog_pkg::ST_IDLE;
            pre <= `WDG_PRE_ZERO;
            cnt <= `WDG_RLD_RESET;
            fire_ticks <= `WDG_TICK_ZERO;
            hw_seen <= 1'b0;
            sys_reset_out <= 1'b0;
            running_out <= 1'b0;
        end else begin
            hw_seen <= 1'b1;
            case (state)
                independent_watchdog_pkg::ST_IDLE: begin
                    if (next_start) begin
                        state <= independent_watchdog_pkg::ST_RUN;
                        running_out <= 1'b1;
                        cnt <= ls_reload;
                        pre <= `WDG_PRE_ZERO;
                    end
                end
                independent_watchdog_pkg::ST_RUN: begin
                    if (refr_evt) begin
                        cnt <= rld_evt ? reload : ls_reload;
                        pre <= `WDG_PRE_ZERO;
                    end else if (!frozen) begin
                        pre <= tick ? `WDG_PRE_ZERO : 8'(pre + 8'h1);
                        if (tick) begin
                            if (cnt == `WDG_CNT_ZERO) begin
                                state <= independent_watchdog_pkg::ST_FIRE;
                                sys_reset_out <= 1'b1;
                                fire_ticks <= `WDG_RESET_PULSE_TICKS;
                            end else begin
                                cnt <= 12'(cnt - 12'h1);
                            end
                        end
                    end
                end
                independent_watchdog_pkg::ST_FIRE: begin
                    // Held until system reset clears the block; pulse bound as fallback
                    if (fire_ticks == `WDG_TICK_ZERO) begin
                        sys_reset_out <= 1'b0;
                        state <= independent_watchdog_pkg::ST_RUN;
                        cnt <= ls_reload;
                    end else begin
                        fire_ticks <= 4'(fire_ticks - 4'h1);
                    end
                end
                default: begin
                    state <= independent_watchdog_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_RELOCK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (key_wr && !key_unlock && !standby_in) |=> !unlocked)
        else $error("protection not restored");
    AST_UNLOCK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (key_unlock && !standby_in) |=> unlocked)
        else $error("unlock key ignored");
    AST_LOCKED_DIV: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (div_wr && !unlocked) |=> $stable(div_code))
        else $error("locked divider written");
    AST_LOCKED_RLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (rld_wr && (!unlocked || rld_pending) && !standby_in) |=> $stable(reload))
        else $error("locked reload written");
    AST_KEY_READ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (rd_in && addr_in == `WDG_OFS_KEY) |=> rdata_out == 32'h0)
        else $error("key read not zero");
    AST_DIV_FLAG: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        div_accept |=> div_pending)
        else $error("divider flag not set");
    AST_RLD_FLAG: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rld_accept |=> rld_pending)
        else $error("reload flag not set");
    AST_STS_READ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (rd_in && addr_in == `WDG_OFS_STS) |=> rdata_out[1:0] == $past({rld_pending, div_pending}))
        else $error("status read wrong");
    AST_FIRE: assert property (@(posedge low_speed_internal_clock_in) disable iff (!ls_rst_n)
        (state == independent_watchdog_pkg::ST_RUN && !refr_evt && !frozen && tick && cnt == `WDG_CNT_ZERO)
        |=> sys_reset_out)
        else $error("no reset at zero");
    AST_FREEZE: assert property (@(posedge low_speed_internal_clock_in) disable iff (!ls_rst_n)
        (state == independent_watchdog_pkg::ST_RUN && frozen && !refr_evt) |=> $stable(cnt))
        else $error("counter moved in halt");
    AST_REFRESH: assert property (@(posedge low_speed_internal_clock_in) disable iff (!ls_rst_n)
        (state == independent_watchdog_pkg::ST_RUN && refr_evt && !rld_evt) |=> cnt == $past(ls_reload))
        else $error("refresh did not reload");
    AST_DIV_WRITE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        div_accept |=> div_code == $past(wdata_in[2:0]))
        else $error("divider write lost");
    AST_RLD_WRITE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (rld_accept && !standby_in) |=> reload == $past(wdata_in[11:0]))
        else $error("reload write lost");
    AST_STBY_RLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        standby_in |=> (reload == `WDG_RLD_RESET && !unlocked))
        else $error("standby did not reset reload");
    AST_DIV_READ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (rd_in && addr_in == `WDG_OFS_DIV) |=> rdata_out == {29'h0, $past(div_code)})
        else $error("divider read wrong");
    AST_RD_IDLE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !rd_in |=> rdata_out == 32'h0)
        else $error("read data not cleared");
    AST_START: assert property (@(posedge low_speed_internal_clock_in) disable iff (!ls_rst_n)
        (state == independent_watchdog_pkg::ST_IDLE && next_start)
        |=> (running_out && state == independent_watchdog_pkg::ST_RUN))
        else $error("counter did not start");
    AST_FIRE_END: assert property (@(posedge low_speed_internal_clock_in) disable iff (!ls_rst_n)
        (state == independent_watchdog_pkg::ST_FIRE && fire_ticks == `WDG_TICK_ZERO) |=> !sys_reset_out)
        else $error("reset pulse not ended");

endmodule // independent_watchdog

`default_nettype wire

// ### verification/independent_watchdog_tb_top.sv
// Self-checking bench of the independent watchdog, random data from an LFSR.
// Assumes the design package, constants header and module are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "independent_watchdog_consts.svh"

module independent_watchdog_tb_top;
    localparam int RLD = 3;
    logic clk, lsi, rst_n, wr, rd, hw, halt, dstop, stby, sys_rst, running;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, v, r;
    logic [31:0] seed = 32'h0286;
    int num_errors = 0;
    int num_checks = 0;
    int n;

    independent_watchdog i_independent_watchdog (.clk_in(clk), .rst_n_in(rst_n),
        .low_speed_internal_clock_in(lsi), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .hw_watchdog_in(hw), .debug_halt_in(halt), .debug_config_stop_in(dstop),
        .standby_in(stby), .sys_reset_out(sys_rst), .running_out(running));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Offset phase keeps low-speed edges off bus edges
    initial begin
        lsi = 1'b0;
        #1.3;
        forever #20 lsi = ~lsi;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic int tick(input int code);
        return 4 << code;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        rd_reg(a, v);
        check(v, exp);
    endtask

    task automatic key(input logic [15:0] k);
        wr_reg(`WDG_OFS_KEY, {16'h0, k});
    endtask

    // Bounded poll, a flag still set after 200 reads counts as an error
    task automatic wait_idle();
        n = 0;
        do begin
            rd_reg(`WDG_OFS_STS, v);
            n++;
        end while (v !== 32'h0 && n < 200);
        if (v !== 32'h0) num_errors++;
    endtask

    task automatic time_to_reset(input int limit);
        n = 0;
        while (sys_rst !== 1'b1 && n < limit) begin
            @(posedge lsi);
            // Look past the edge that launches the reset
            #1;
            n++;
        end
    endtask

    // Extra low-speed edges so the counter domain sees the reset
    task automatic do_reset(input logic hw_opt);
        @(posedge clk);
        rst_n <= 1'b0;
        hw <= hw_opt;
        repeat (8) @(posedge clk);
        repeat (3) @(posedge lsi);
        @(posedge clk);
        rst_n <= 1'b1;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #380000;
        num_errors++;
        results();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        hw = 1'b0;
        halt = 1'b0;
        dstop = 1'b0;
        stby = 1'b0;
        do_reset(1'b0);
        rd_chk(`WDG_OFS_KEY, 32'h0);
        rd_chk(`WDG_OFS_DIV, 32'h0);
        rd_chk(`WDG_OFS_RLD, 32'h0000_0fff);
        rd_chk(`WDG_OFS_STS, 32'h0);
        rd_chk(4'h2, 32'h0);
        repeat (20) @(posedge lsi);
        check(32'(running), 32'h0);
        $display("test reset values done");

        wr_reg(`WDG_OFS_DIV, 32'h5);
        wr_reg(`WDG_OFS_RLD, 32'h123);
        rd_chk(`WDG_OFS_DIV, 32'h0);
        rd_chk(`WDG_OFS_RLD, 32'h0000_0fff);
        seed = lfsr(seed);
        r = {20'h0, seed[11:0]};
        key(`WDG_KEY_UNLOCK);
        wr_reg(`WDG_OFS_RLD, r);
        rd_reg(`WDG_OFS_STS, v);
        check(v & 32'h2, 32'h2);
        wr_reg(`WDG_OFS_RLD, ~r);
        wait_idle();
        rd_chk(`WDG_OFS_RLD, r);
        seed = lfsr(seed);
        key({seed[15:1], 1'b0});
        wr_reg(`WDG_OFS_RLD, ~r);
        wait_idle();
        rd_chk(`WDG_OFS_RLD, r);
        key(`WDG_KEY_UNLOCK);
        key(`WDG_KEY_REFRESH);
        wr_reg(`WDG_OFS_RLD, ~r);
        wait_idle();
        rd_chk(`WDG_OFS_RLD, r);
        rd_chk(`WDG_OFS_KEY, 32'h0);
        $display("test protection done");

        key(`WDG_KEY_UNLOCK);
        wr_reg(`WDG_OFS_RLD, 32'(RLD));
        wait_idle();
        for (int c = 0; c < 7; c++) begin
            key(`WDG_KEY_UNLOCK);
            wr_reg(`WDG_OFS_DIV, 32'(c));
            rd_reg(`WDG_OFS_STS, v);
            check(v & 32'h1, 32'h1);
            wait_idle();
            rd_chk(`WDG_OFS_DIV, 32'(c));
            if (c == 0) begin
                key(`WDG_KEY_START);
                repeat (10) @(posedge lsi);
                check(32'(running), 32'h1);
            end
            // Refresh just after a timeout, so no timeout lands while it syncs
            while (sys_rst !== 1'b1) @(posedge lsi);
            while (sys_rst !== 1'b0) @(posedge lsi);
            key(`WDG_KEY_REFRESH);
            time_to_reset(3000);
            check(32'(n >= (RLD - 1) * tick(c) && n <= (RLD + 2) * tick(c) + 8), 32'h1);
        end
        $display("test divider timeouts done");

        key(`WDG_KEY_UNLOCK);
        wr_reg(`WDG_OFS_DIV, 32'h0);
        wait_idle();
        while (sys_rst !== 1'b1) @(posedge lsi);
        while (sys_rst !== 1'b0) @(posedge lsi);
        repeat (20) begin
            key(`WDG_KEY_REFRESH);
            time_to_reset(8);
            check(32'(n), 32'h8);
        end
        $display("test refresh done");

        key(`WDG_KEY_REFRESH);
        halt <= 1'b1;
        dstop <= 1'b1;
        time_to_reset(200);
        check(32'(n), 32'd200);
        @(posedge clk);
        dstop <= 1'b0;
        time_to_reset(200);
        check(32'(n < 200), 32'h1);
        @(posedge clk);
        halt <= 1'b0;
        $display("test debug halt done");

        key(`WDG_KEY_UNLOCK);
        stby <= 1'b1;
        repeat (4) @(posedge lsi);
        @(posedge clk);
        stby <= 1'b0;
        rd_chk(`WDG_OFS_RLD, 32'h0000_0fff);
        wr_reg(`WDG_OFS_RLD, 32'h9);
        wait_idle();
        rd_chk(`WDG_OFS_RLD, 32'h0000_0fff);
        $display("test standby done");

        do_reset(1'b1);
        repeat (20) @(posedge lsi);
        check(32'(running), 32'h1);
        $display("test hardware option done");
        results();
    end
endmodule // independent_watchdog_tb_top

`default_nettype wire
